// ---- core/timekeeper_pkg.sv ----
// Contract
// - timing reference is the 32.768 kHz crystal
// - trim corrects crystal offset and thermal drift
// - keeps running in every power saving mode
// - counters survive soft resets, clear on power-on
// - day rollover sets flag, software writes zero
// - 24-hour mode: flag once per day
// - 256-hour mode: hours wrap 255 to 0
// - 24-hour mode: hours wrap 23 to 0
// - hour mode and run enable survive soft resets
// - span base: tick, second, minute, hour
// - repeating mode: alarm then new interval
// - one-shot mode: single alarm, no repeat
// - alarm flag set on elapse, software clears
// - span timer off holds its count at zero
// - span counts only with timer on and running
// - run clear stops, clears counters, stops strobe
// - run set enables timekeeper and adc strobe
// - fraction counts 1/128 s, wraps 127, carries
// - seconds, minutes wrap 59 and carry on
// - hour wrap sets flag and interrupt pending
// - count equals target: alarm and interrupt pending
package timekeeper_pkg;

    // ====================================================
    // register offsets
    localparam logic [7:0] ADDR_CONFIG = 8'ha1;
    localparam logic [7:0] ADDR_FRAC = 8'ha2;
    localparam logic [7:0] ADDR_ONE_HZ = 8'ha3;
    localparam logic [7:0] ADDR_SIXTY = 8'ha4;
    localparam logic [7:0] ADDR_HOUR = 8'ha5;
    localparam logic [7:0] ADDR_TARGET = 8'ha6;
    localparam logic [7:0] ADDR_NOMINAL = 8'hf6;
    localparam logic [7:0] ADDR_THERMAL = 8'hf7;

    // ====================================================
    // field positions and reset values
    localparam int BIT_RUN = 0;
    localparam int BIT_SPAN_ON = 1;
    localparam int BIT_ALARM = 2;
    localparam int BIT_ONE_SHOT = 3;
    localparam int BIT_BASE_LO = 4;
    localparam int BIT_DAY_24 = 6;
    localparam int BIT_ROLLOVER = 7;
    localparam logic [7:0] CONFIG_POR = 8'h01;

    // ====================================================
    // counts
    localparam logic [7:0] FRAC_LAST = 8'h7f;
    localparam logic [7:0] SIXTY_LAST = 8'h3b;
    localparam logic [7:0] HOUR_LAST_24 = 8'h17;
    localparam logic [7:0] HOUR_LAST_256 = 8'hff;
    localparam real XTAL_KHZ = 32.768;
    localparam logic [8:0] XTAL_EDGES_LAST = 9'h0ff;
    localparam logic [7:0] TRIM_MAX = 8'h7f;

    // ====================================================
    // types
    typedef enum logic [1:0] {BASE_FRAC, BASE_SECOND, BASE_MINUTE, BASE_HOUR} span_base_type;

    typedef struct packed {
        logic day_rollover_flag;
        logic day_mode_24;
        span_base_type span_base_select;
        logic one_shot_select;
        logic alarm_flag;
        logic span_timer_on;
        logic clock_run_enable;
    } config_type;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_type;

    typedef struct packed {
        config_type cfg;
        logic [3:0][7:0] count;
        logic [7:0] target;
        logic [7:0] nominal;
        logic [7:0] thermal;
        logic [7:0] rdata;
        logic hit;
        logic irq;
        logic strobe;
    } keeper_state_type;

    typedef struct packed {
        logic xtal_prev;
        logic [8:0] edges;
        logic [6:0] slot;
        logic tick;
    } divider_state_type;

    typedef struct packed {
        logic [7:0] count;
        logic done;
        logic elapsed;
    } span_state_type;

endpackage

// ---- core/xtal_tick_divider.sv ----
module xtal_tick_divider
    import timekeeper_pkg::*;
(
    input wire logic clk_sys,
    input wire logic por,
    input wire logic xtal_in,
    input wire logic run,
    input wire logic [7:0] nominal_trim,
    input wire logic [7:0] thermal_trim,
    output logic frac_tick
);

    divider_state_type st;
    divider_state_type next_st;
    logic signed [8:0] trim_sum;
    logic [7:0] trim_mag;
    logic [8:0] period_last;

    // ====================================================
    // trimmed prescaler
    // the trim is spread over the first slots of each second, so one slot
    // never moves by more than one crystal edge
    always_comb begin
        trim_sum = $signed({nominal_trim[7], nominal_trim}) + $signed({thermal_trim[7], thermal_trim});
        trim_mag = trim_sum[8] ? 8'(-trim_sum) : trim_sum[7:0];
        if (trim_mag > TRIM_MAX) begin
            trim_mag = TRIM_MAX;
        end
        period_last = XTAL_EDGES_LAST;
        if ({1'b0, st.slot} < trim_mag) begin
            period_last = trim_sum[8] ? XTAL_EDGES_LAST + 9'h001 : XTAL_EDGES_LAST - 9'h001;
        end
        next_st = st;
        next_st.tick = 1'b0;
        next_st.xtal_prev = xtal_in;
        if (!run) begin
            next_st.edges = '0;
            next_st.slot = '0;
        end else if (xtal_in && !st.xtal_prev) begin
            if (st.edges >= period_last) begin
                next_st.edges = '0;
                next_st.tick = 1'b1;
                next_st.slot = st.slot + 7'h01;
            end else begin
                next_st.edges = st.edges + 9'h001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (por) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign frac_tick = st.tick;

    // ====================================================
    // checks
    // tick needs crystal edges
    a_tick_spacing: assert property (@(posedge clk_sys) disable iff (por)
        st.tick |-> st.edges == 9'h000)
        else $error("tick without prescaler wrap");

endmodule

// ---- core/span_timer.sv ----
module span_timer
    import timekeeper_pkg::*;
(
    input wire logic clk_sys,
    input wire logic por,
    input wire logic reset,
    input wire logic [3:0] base_ticks,
    input wire span_base_type base,
    input wire logic hold_zero,
    input wire logic one_shot,
    input wire logic [7:0] target,
    output logic [7:0] span_count,
    output logic span_elapsed
);

    span_state_type st;
    span_state_type next_st;
    logic [7:0] count_inc;

    always_comb begin
        next_st = st;
        next_st.elapsed = 1'b0;
        count_inc = st.count + 8'h01;
        if (hold_zero) begin
            next_st.count = '0;
            next_st.done = 1'b0;
        end else if (base_ticks[base] && !st.done) begin
            next_st.count = count_inc;
            if (count_inc == target) begin
                next_st.elapsed = 1'b1;
                next_st.done = one_shot;
                if (!one_shot) begin
                    next_st.count = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (por || reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign span_count = st.count;
    assign span_elapsed = st.elapsed;

    // ====================================================
    // checks
    a_repeat_restart: assert property (@(posedge clk_sys) disable iff (por || reset)
        st.elapsed && !st.done |-> st.count == 8'h00)
        else $error("repeat interval did not restart");
    a_one_shot_stop: assert property (@(posedge clk_sys) disable iff (por || reset)
        st.done && !hold_zero |=> !st.elapsed && $stable(st.count))
        else $error("one-shot timer kept running");

endmodule

// ---- core/rtc_timekeeper.sv ----
module rtc_timekeeper
    import timekeeper_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic por,
    input wire logic xtal_in,
    input wire sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_read_hit,
    output logic rtc_irq_pulse,
    output logic adc_strobe_enable,
    output logic adc_strobe
);

    keeper_state_type st;
    keeper_state_type next_st;
    logic frac_tick;
    logic run;
    logic [4:0] carry;
    logic [3:0][7:0] last;
    logic day_wrap;
    logic span_hold;
    logic [7:0] span_count;
    logic span_elapsed;
    logic clean;

    assign run = st.cfg.clock_run_enable;
    assign clean = !reset && !sfr_req.wr;

    // ====================================================
    // prescaler and interval timer
    xtal_tick_divider u_divider (
        .clk_sys(clk_sys),
        .por(por),
        .xtal_in(xtal_in),
        .run(run),
        .nominal_trim(st.nominal),
        .thermal_trim(st.thermal),
        .frac_tick(frac_tick)
    );

    assign span_hold = !st.cfg.span_timer_on || !run;

    span_timer u_span (
        .clk_sys(clk_sys),
        .por(por),
        .reset(reset),
        .base_ticks(carry[3:0]),
        .base(st.cfg.span_base_select),
        .hold_zero(span_hold),
        .one_shot(st.cfg.one_shot_select),
        .target(st.target),
        .span_count(span_count),
        .span_elapsed(span_elapsed)
    );

    // ====================================================
    // counter chain
    always_comb begin
        last[0] = FRAC_LAST;
        last[1] = SIXTY_LAST;
        last[2] = SIXTY_LAST;
        last[3] = st.cfg.day_mode_24 ? HOUR_LAST_24 : HOUR_LAST_256;
        carry[0] = frac_tick && run;
        for (int i = 0; i < 4; i++) begin
            carry[i + 1] = carry[i] && (st.count[i] == last[i]);
        end
    end

    assign day_wrap = carry[4];

    // ====================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.strobe = 1'b0;
        next_st.hit = 1'b0;
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                ADDR_CONFIG: next_st.cfg = config_type'(sfr_req.wdata);
                ADDR_TARGET: next_st.target = sfr_req.wdata;
                ADDR_NOMINAL: next_st.nominal = sfr_req.wdata;
                ADDR_THERMAL: next_st.thermal = sfr_req.wdata;
                default: next_st.target = st.target;
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            if (!run) begin
                next_st.count[i] = '0;
            end else if (sfr_req.wr && sfr_req.addr == ADDR_FRAC + 8'(i)) begin
                next_st.count[i] = sfr_req.wdata;
            end else if (carry[i]) begin
                next_st.count[i] = carry[i + 1] ? 8'h00 : st.count[i] + 8'h01;
            end
        end
        if (day_wrap) begin
            next_st.cfg.day_rollover_flag = 1'b1;
        end
        if (span_elapsed) begin
            next_st.cfg.alarm_flag = 1'b1;
        end
        next_st.irq = day_wrap || span_elapsed;
        next_st.strobe = carry[1];
        if (sfr_req.rd) begin
            next_st.hit = 1'b1;
            unique case (sfr_req.addr)
                ADDR_CONFIG: next_st.rdata = st.cfg;
                ADDR_FRAC: next_st.rdata = st.count[0];
                ADDR_ONE_HZ: next_st.rdata = st.count[1];
                ADDR_SIXTY: next_st.rdata = st.count[2];
                ADDR_HOUR: next_st.rdata = st.count[3];
                ADDR_TARGET: next_st.rdata = st.target;
                ADDR_NOMINAL: next_st.rdata = st.nominal;
                ADDR_THERMAL: next_st.rdata = st.thermal;
                default: begin
                    next_st.hit = 1'b0;
                    next_st.rdata = 8'h00;
                end
            endcase
        end
        if (reset) begin
            next_st.cfg = config_type'(CONFIG_POR & 8'h00);
            next_st.cfg.day_mode_24 = st.cfg.day_mode_24;
            next_st.cfg.clock_run_enable = st.cfg.clock_run_enable;
            next_st.target = '0;
            next_st.rdata = '0;
            next_st.hit = 1'b0;
            next_st.irq = 1'b0;
            next_st.strobe = 1'b0;
        end
    end

    // of the two resets only power-on clears the time, trims and hour mode, and it sets run enable
    always_ff @(posedge clk_sys) begin
        if (por) begin
            st <= '0;
            st.cfg <= config_type'(CONFIG_POR);
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign sfr_read_hit = st.hit;
    assign rtc_irq_pulse = st.irq;
    assign adc_strobe_enable = run;
    assign adc_strobe = st.strobe && run;

    // ====================================================
    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (por);

    a_frac_wrap: assert property (
        carry[0] && st.count[0] == FRAC_LAST && clean |=> st.count[0] == 8'h00)
        else $error("fraction did not wrap at 127");
    a_sixty_wrap: assert property (
        carry[1] && st.count[1] == SIXTY_LAST && clean |=> st.count[1] == 8'h00
            && st.count[2] == $past(st.count[2]) + 8'h01 || $past(st.count[2]) == SIXTY_LAST)
        else $error("seconds did not wrap at 59 with carry");
    a_hour_24: assert property (
        day_wrap && st.cfg.day_mode_24 && clean |=> st.count[3] == 8'h00
            && st.cfg.day_rollover_flag && rtc_irq_pulse)
        else $error("24-hour wrap wrong");
    a_hour_256: assert property (
        carry[3] && !st.cfg.day_mode_24 && st.count[3] == 8'hfe && clean |=> st.count[3] == 8'hff)
        else $error("256-hour mode wrapped early");
    a_day_bound: assert property (
        st.cfg.day_mode_24 && st.count[3] < 8'h18 && clean |=> st.count[3] < 8'h18)
        else $error("hour left 0 to 23");
    a_flag_set_wins: assert property (
        day_wrap && sfr_req.wr && sfr_req.addr == ADDR_CONFIG && !reset
            |=> st.cfg.day_rollover_flag)
        else $error("rollover lost under clear");
    a_run_clears: assert property (
        !run && !reset ##1 !run |-> st.count == '0 && span_count == 8'h00 && !adc_strobe)
        else $error("stopped timekeeper not cleared");
    a_span_off: assert property (
        !st.cfg.span_timer_on |=> span_count == 8'h00)
        else $error("span count not held at zero");
    a_alarm_set: assert property (
        span_elapsed && !reset |=> st.cfg.alarm_flag && rtc_irq_pulse)
        else $error("alarm flag not set");
    a_soft_retain: assert property (
        reset && !carry[0] |=> st.count == $past(st.count)
            && st.cfg.clock_run_enable == $past(st.cfg.clock_run_enable))
        else $error("soft reset disturbed time");

    c_day_wrap: cover property (day_wrap && st.cfg.day_mode_24);
    c_span_repeat: cover property (span_elapsed && !st.cfg.one_shot_select);
    c_span_one_shot: cover property (span_elapsed && st.cfg.one_shot_select);
    c_soft_reset_run: cover property (reset && run && carry[0]);

endmodule

// ---- verif/rtc_timekeeper_tb.sv ----
module rtc_timekeeper_tb;
    import timekeeper_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // one fraction tick: 256 crystal rises, 4 clocks apart, no trim
    localparam int TICK = 1024;
    localparam int WAIT2 = 2 * TICK + 60;
    localparam int LIMIT = 90000;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic por = 1'b1;
    logic xtal_in = 1'b0;
    sfr_req_type sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic sfr_read_hit;
    logic rtc_irq_pulse;
    logic adc_strobe_enable;
    logic adc_strobe;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int strobes = 0;
    int irq_at[$];

    rtc_timekeeper rtc_timekeeper_inst (
        .clk_sys(clk_sys),
        .reset(reset),
        .por(por),
        .xtal_in(xtal_in),
        .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata),
        .sfr_read_hit(sfr_read_hit),
        .rtc_irq_pulse(rtc_irq_pulse),
        .adc_strobe_enable(adc_strobe_enable),
        .adc_strobe(adc_strobe)
    );

    // ====================================================
    // clock, crystal stand-in, monitor
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // crystal runs far faster than real so a tick costs 1024 clocks
    initial begin
        forever begin
            repeat (2) @(posedge clk_sys);
            #1 xtal_in = ~xtal_in;
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (rtc_irq_pulse === 1'b1) irq_at.push_back(cycles);
        if (adc_strobe === 1'b1) strobes++;
        if (cycles >= LIMIT) begin
            errors++;
            final_report();
        end
    end

    // ====================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req.addr = a;
        sfr_req.wdata = d;
        sfr_req.wr = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_req.wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [8:0] v);
        sfr_req.addr = a;
        sfr_req.rd = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_req.rd = 1'b0;
        v = {sfr_read_hit, sfr_rdata};
        if (sfr_read_hit !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            v = {sfr_read_hit, sfr_rdata};
        end
        @(posedge clk_sys);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [8:0] v;
        rd(a, v);
        check(v, {1'b1, e});
    endtask

    // fraction written last so the next tick sees the whole preload
    task automatic load(input logic [7:0] h, m, s, f);
        wr(ADDR_HOUR, h);
        wr(ADDR_SIXTY, m);
        wr(ADDR_ONE_HZ, s);
        wr(ADDR_FRAC, f);
    endtask

    task automatic wait_irq(input int n, output logic got);
        int start;
        start = irq_at.size();
        got = 1'b0;
        for (int i = 0; i < n && !got; i++) begin
            @(posedge clk_sys);
            #1;
            got = (irq_at.size() != start);
        end
    endtask

    task automatic soft_reset(input logic power);
        if (power) por = 1'b1;
        else reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        por = 1'b0;
        reset = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    // ====================================================
    // scenarios
    task automatic t_por();
        logic [8:0] v;
        rchk(ADDR_CONFIG, CONFIG_POR);
        for (int a = 'ha2; a < 'ha7; a++) rchk(8'(a), 8'h00);
        rchk(ADDR_NOMINAL, 8'h00);
        rchk(ADDR_THERMAL, 8'h00);
        check(adc_strobe_enable, 1'b1);
        rd(8'ha7, v);
        check(v, 9'h000);
        wr(ADDR_THERMAL, 8'h5a);
        rchk(ADDR_THERMAL, 8'h5a);
        wr(ADDR_THERMAL, 8'h00);
    endtask

    task automatic t_day24();
        logic got;
        int s0;
        wr(ADDR_CONFIG, 8'h41);
        load(8'h17, 8'h3b, 8'h3b, 8'h7f);
        s0 = strobes;
        wait_irq(WAIT2, got);
        check(got, 1'b1);
        check(strobes - s0, 1);
        rchk(ADDR_HOUR, 8'h00);
        rchk(ADDR_SIXTY, 8'h00);
        rchk(ADDR_ONE_HZ, 8'h00);
        rchk(ADDR_FRAC, 8'h00);
        rchk(ADDR_CONFIG, 8'hc1);
        wr(ADDR_CONFIG, 8'h41);
        rchk(ADDR_CONFIG, 8'h41);
        wait_irq(WAIT2, got);
        check(got, 1'b0);
        rchk(ADDR_FRAC, 8'h02);
    endtask

    task automatic t_day256();
        logic got;
        wr(ADDR_CONFIG, 8'h01);
        load(8'h17, 8'h3b, 8'h3b, 8'h7f);
        wait_irq(WAIT2, got);
        check(got, 1'b0);
        rchk(ADDR_HOUR, 8'h18);
        load(8'hff, 8'h3b, 8'h3b, 8'h7f);
        wait_irq(WAIT2, got);
        check(got, 1'b1);
        rchk(ADDR_HOUR, 8'h00);
        rchk(ADDR_CONFIG, 8'h81);
    endtask

    task automatic t_reset();
        wr(ADDR_CONFIG, 8'h5b);
        wr(ADDR_TARGET, 8'h07);
        wr(ADDR_HOUR, 8'h05);
        soft_reset(1'b0);
        rchk(ADDR_CONFIG, 8'h41);
        rchk(ADDR_HOUR, 8'h05);
        rchk(ADDR_TARGET, 8'h00);
        soft_reset(1'b1);
        rchk(ADDR_CONFIG, CONFIG_POR);
        rchk(ADDR_HOUR, 8'h00);
    endtask

    task automatic t_repeat();
        int n0;
        wr(ADDR_TARGET, 8'h03);
        n0 = irq_at.size();
        wr(ADDR_CONFIG, 8'h03);
        for (int i = 0; i < 12 * TICK && irq_at.size() < n0 + 3; i++) @(posedge clk_sys);
        #1;
        check(irq_at.size(), n0 + 3);
        check(irq_at[n0 + 1] - irq_at[n0], 3 * TICK);
        check(irq_at[n0 + 2] - irq_at[n0 + 1], 3 * TICK);
        rchk(ADDR_CONFIG, 8'h07);
        wr(ADDR_CONFIG, 8'h03);
        rchk(ADDR_CONFIG, 8'h03);
        wr(ADDR_CONFIG, 8'h01);
    endtask

    task automatic t_one_shot();
        logic got;
        wr(ADDR_TARGET, 8'h02);
        wr(ADDR_CONFIG, 8'h0b);
        wait_irq(3 * TICK, got);
        check(got, 1'b1);
        wait_irq(5 * TICK, got);
        check(got, 1'b0);
        rchk(ADDR_CONFIG, 8'h0f);
        wr(ADDR_CONFIG, 8'h01);
    endtask

    // each base from second to hour fires on its own carry, not on the one below it
    task automatic t_bases();
        logic got;
        for (int b = 1; b < 4; b++) begin
            wr(ADDR_CONFIG, 8'h01);
            wr(ADDR_TARGET, 8'h01);
            wr(ADDR_CONFIG, 8'h03 | 8'(b << 4));
            load(8'h00, 8'h00, (b > 2) ? 8'h3b : 8'h00, (b > 1) ? 8'h7f : 8'h00);
            wait_irq(WAIT2, got);
            check(got, 1'b0);
            load(8'h00, (b > 2) ? 8'h3b : 8'h00, (b > 1) ? 8'h3b : 8'h00, 8'h7f);
            wait_irq(WAIT2, got);
            check(got, 1'b1);
        end
        wr(ADDR_CONFIG, 8'h01);
    endtask

    task automatic t_run_off();
        logic got;
        int s0;
        wr(ADDR_TARGET, 8'h01);
        wait_irq(3 * TICK, got);
        check(got, 1'b0);
        wr(ADDR_HOUR, 8'h09);
        s0 = strobes;
        wr(ADDR_CONFIG, 8'h02);
        check(adc_strobe_enable, 1'b0);
        rchk(ADDR_HOUR, 8'h00);
        wr(ADDR_SIXTY, 8'h05);
        rchk(ADDR_SIXTY, 8'h00);
        wait_irq(3 * TICK, got);
        check(got, 1'b0);
        check(strobes, s0);
        soft_reset(1'b0);
        rchk(ADDR_CONFIG, 8'h00);
        wr(ADDR_TARGET, 8'h01);
        wr(ADDR_CONFIG, 8'h03);
        check(adc_strobe_enable, 1'b1);
        wait_irq(WAIT2, got);
        check(got, 1'b1);
        wr(ADDR_CONFIG, 8'h01);
    endtask

    // ====================================================
    // run
    task automatic final_report();
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        por = 1'b0;
        reset = 1'b0;
        @(posedge clk_sys);
        #1;
        t_por();
        t_day24();
        t_day256();
        t_reset();
        t_repeat();
        t_one_shot();
        t_bases();
        t_run_off();
        final_report();
    end
endmodule
